// file: rtl/pacr_defs.svh
// Address map, field layout and routing codes of the pixel array configuration store.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef PACR_DEFS_SVH
`define PACR_DEFS_SVH

// ==========================================================
// Address map
`define PACR_PIX_BASE 16'h0000
`define PACR_PIX_LAST 16'h01ff
`define PACR_ROUTE_BASE 16'h0400
`define PACR_ROUTE_LAST 16'h041f
`define PACR_UNMAPPED_DATA 8'h00

// ==========================================================
// Pixel enable byte address layout
`define PACR_ROW_LSB 3
`define PACR_ROW_BITS 6
`define PACR_GRP_BITS 3

// ==========================================================
// Column routing nibble codes
`define PACR_CODE_QA_POS 4'h0
`define PACR_CODE_QA_NEG 4'h1
`define PACR_CODE_QB_POS 4'h2
`define PACR_CODE_QB_NEG 4'h3
`define PACR_CODE_IX_POS 4'h4
`define PACR_CODE_IX_NEG 4'h5

`endif

// file: rtl/pacr_pkg.sv
// Types shared by the pixel array configuration store and its column router.
// Assumes pacr_defs.svh is on the include path.
`include "pacr_defs.svh"

package pacr_pkg;

	// ==========================================================
	// Aggregate destinations, one bit each in a column select vector
	typedef enum {
		QA_POS,
		QA_NEG,
		QB_POS,
		QB_NEG,
		IX_POS,
		IX_NEG
	} pacr_dest_type;

	typedef logic [5:0] pacr_sel_type;

	// Turns a routing nibble into a one-hot select; all zeros means shunt to ground.
	function automatic pacr_sel_type pacr_decode(input logic [3:0] nib);
		pacr_sel_type s;
		s = 6'h00;
		unique case (nib)
			`PACR_CODE_QA_POS: s[QA_POS] = 1'b1;
			`PACR_CODE_QA_NEG: s[QA_NEG] = 1'b1;
			`PACR_CODE_QB_POS: s[QB_POS] = 1'b1;
			`PACR_CODE_QB_NEG: s[QB_NEG] = 1'b1;
			`PACR_CODE_IX_POS: s[IX_POS] = 1'b1;
			`PACR_CODE_IX_NEG: s[IX_NEG] = 1'b1;
			default: s = 6'h00;
		endcase
		return s;
	endfunction

	// Byte address of the eight pixels at a row and a left-to-right group position.
	function automatic logic [15:0] pacr_pix_addr(input logic [5:0] row, input logic [2:0] pos);
		return {7'h00, row, pos[0], pos[2:1]};
	endfunction

endpackage

// file: rtl/pacr_column_router.sv
// Registered decode of the 64 column routing nibbles into destination selects.
// Assumes the routing bytes arrive flattened, byte 0 in the low bits, on the same clock.
`timescale 1ns/1ns

module pacr_column_router #(
	parameter int COLS = 64
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [COLS*4-1:0] route_bytes,
	output logic [COLS*6-1:0] col_sel,
	output logic [COLS-1:0] col_shunt
);

	// ==========================================================
	// Per-column decode
	logic [COLS*6-1:0] next_col_sel;
	logic [COLS-1:0] next_col_shunt;

	genvar c;
	generate
		for (c = 0; c < COLS; c++)
		begin : g_col
			// Low nibble is the left column of a pair, bytes step left to right.
			assign next_col_sel[c*6 +: 6] = pacr_pkg::pacr_decode(route_bytes[c*4 +: 4]);
			assign next_col_shunt[c] = (pacr_pkg::pacr_decode(route_bytes[c*4 +: 4]) == 6'h00);
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			col_sel <= '0;
			col_shunt <= '1;
		end
		else
		begin
			col_sel <= next_col_sel;
			col_shunt <= next_col_shunt;
		end
	end

endmodule

// file: rtl/pacr_config_store.sv
// Volatile pixel enable and column routing store of a 64 by 64 photosensor array.
// Assumes the serial port engine hands over byte reads and writes as one-cycle strobes on sys_clk.
`timescale 1ns/1ns
`include "pacr_defs.svh"

module pacr_config_store #(
	parameter int ROWS = 64,
	parameter int COLS = 64
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic [ROWS*COLS-1:0] pixel_enable_bits,
	output logic [COLS*6-1:0] col_sel,
	output logic [COLS-1:0] col_shunt
);

	localparam int PIX_BYTES = ROWS * COLS / 8;
	localparam int ROUTE_BYTES = COLS / 2;

	// ==========================================================
	// Storage, deliberately without reset: contents are random at power-on
	logic [7:0] pixel_mem [PIX_BYTES];
	logic [7:0] route_mem [ROUTE_BYTES];

	// ==========================================================
	// Address decode
	wire pix_hit = (reg_addr >= `PACR_PIX_BASE) && (reg_addr <= `PACR_PIX_LAST);
	wire route_hit = (reg_addr >= `PACR_ROUTE_BASE) && (reg_addr <= `PACR_ROUTE_LAST);
	wire [8:0] pix_index = reg_addr[8:0];
	wire [4:0] route_index = reg_addr[4:0];
	wire [7:0] next_rdata = pix_hit ? pixel_mem[pix_index] :
		route_hit ? route_mem[route_index] : `PACR_UNMAPPED_DATA;

	always_ff @(posedge sys_clk)
	begin
		if (reg_wr && pix_hit)
			pixel_mem[pix_index] <= reg_wdata;
		if (reg_wr && route_hit)
			route_mem[route_index] <= reg_wdata;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? next_rdata : reg_rdata;
			reg_rvalid <= reg_rd;
		end
	end

	// ==========================================================
	// Pixel enable fan-out: row-major, columns left to right
	genvar r;
	genvar c;
	generate
		for (r = 0; r < ROWS; r++)
		begin : g_row
			for (c = 0; c < COLS; c++)
			begin : g_pix
				localparam logic [15:0] A = pacr_pkg::pacr_pix_addr(6'(r), 3'(c / 8));
				assign pixel_enable_bits[r*COLS + c] = pixel_mem[A[8:0]][c % 8];
			end
		end
	endgenerate

	// ==========================================================
	// Column routing
	logic [COLS*4-1:0] route_flat;
	genvar b;
	generate
		for (b = 0; b < ROUTE_BYTES; b++)
		begin : g_route
			assign route_flat[b*8 +: 8] = route_mem[b];
		end
	endgenerate

	pacr_column_router #(
		.COLS(COLS)
	) pacr_column_router_i (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.route_bytes(route_flat),
		.col_sel(col_sel),
		.col_shunt(col_shunt)
	);

	// ==========================================================
	// Checks
	property p_pix_readback;
		@(posedge sys_clk) disable iff (sys_rst)
		(reg_wr && pix_hit) ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr))
		|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_pix_readback: assert property (p_pix_readback) else $error("pixel byte read differs from last write");

	property p_route_readback;
		@(posedge sys_clk) disable iff (sys_rst)
		(reg_wr && route_hit) ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr))
		|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_route_readback: assert property (p_route_readback) else $error("routing byte read differs from last write");

	property p_gap_reads_zero;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && !pix_hit && !route_hit |=> reg_rdata == 8'h00 && reg_rvalid;
	endproperty
	a_gap_reads_zero: assert property (p_gap_reads_zero) else $error("unmapped read did not return zero");

	property p_first_byte;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == 16'h0000 |=> pixel_enable_bits[0] == $past(reg_wdata[0])
			&& pixel_enable_bits[7] == $past(reg_wdata[7]);
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("top-left pixel byte not mapped left to right");

	property p_group_order;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == 16'h0004 |=> pixel_enable_bits[8] == $past(reg_wdata[0]);
	endproperty
	a_group_order: assert property (p_group_order) else $error("group 4 is not second from the left");

	property p_bottom_row;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == 16'h01ff |=> pixel_enable_bits[4095] == $past(reg_wdata[7]);
	endproperty
	a_bottom_row: assert property (p_bottom_row) else $error("last byte does not reach bottom-right pixel");

	property p_left_route;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == 16'h0400 ##1 !(reg_wr && route_hit)
		|=> col_sel[5:0] == 6'(7'h01 << $past(reg_wdata[3:0], 2))
			&& col_shunt[0] == ($past(reg_wdata[3:0], 2) > 4'h5);
	endproperty
	a_left_route: assert property (p_left_route) else $error("leftmost column route wrong after write");

	property p_right_route;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == 16'h041f ##1 !(reg_wr && route_hit)
		|=> col_sel[383:378] == 6'(7'h01 << $past(reg_wdata[7:4], 2));
	endproperty
	a_right_route: assert property (p_right_route) else $error("rightmost column route wrong after write");

	// Column 0 has a defined route only once its byte is written and has passed the router stage.
	logic route0_written;
	logic route0_settled;

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			route0_written <= 1'b0;
			route0_settled <= 1'b0;
		end
		else
		begin
			route0_written <= route0_written || (reg_wr && reg_addr == `PACR_ROUTE_BASE);
			route0_settled <= route0_written;
		end
	end

	property p_one_destination;
		@(posedge sys_clk) disable iff (sys_rst)
		route0_settled |-> $onehot(col_sel[5:0]) != col_shunt[0];
	endproperty
	a_one_destination: assert property (p_one_destination) else $error("column has no single destination");

	property p_route_pair_right;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == 16'h0400 ##1 !(reg_wr && route_hit)
		|=> col_sel[11:6] == 6'(7'h01 << $past(reg_wdata[7:4], 2))
			&& col_shunt[1] == ($past(reg_wdata[7:4], 2) > 4'h5);
	endproperty
	a_route_pair_right: assert property (p_route_pair_right) else $error("second column ignores the high nibble");

	property p_row_start;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == 16'h01f8 |=> pixel_enable_bits[4032] == $past(reg_wdata[0]);
	endproperty
	a_row_start: assert property (p_row_start) else $error("last row does not start at the left edge");

	property p_rvalid_pulse;
		@(posedge sys_clk) disable iff (sys_rst)
		reg_rd |=> reg_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered in the next cycle");

	property p_rvalid_idle;
		@(posedge sys_clk) disable iff (sys_rst)
		!reg_rd |=> !reg_rvalid;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle) else $error("read valid raised without a read");

	property p_rdata_holds;
		@(posedge sys_clk) disable iff (sys_rst)
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_holds: assert property (p_rdata_holds) else $error("read data changed without a read");

endmodule

// file: test/pacr_nvm_model.sv
// Serial configuration memory model holding one power-up pattern image.
// Assumes the bench reads it combinationally, one byte per address.
`timescale 1ns/1ns

module pacr_nvm_model
(
	input wire logic [9:0] nvm_addr,
	output logic [7:0] nvm_data
);
	// ==========================================
	// Pattern image
	// Pixel bytes in row-major, left-to-right order, then the 32 routing bytes.
	logic [7:0] image [0:1023];
	initial
	begin
		for (int i = 0; i < 1024; i++)
			image[i] = (i < 512) ? (8'(i) ^ 8'h5a) : {4'(i + 3), 4'(i)};
	end
	assign nvm_data = image[nvm_addr];
endmodule

// file: test/pixel_array_route_config_tb_top.sv
// Testbench of the pixel array configuration store.
// Assumes the byte strobe port of the store and the pattern memory model.
`timescale 1ns/1ns

module pixel_array_route_config_tb_top;
	logic sys_clk, sys_rst, reg_wr, reg_rd, reg_rvalid;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, nvm_data;
	logic [9:0] nvm_addr;
	logic [4095:0] pixel_enable_bits;
	logic [383:0] col_sel;
	logic [63:0] col_shunt;
	int fail_count = 0;
	int n_tests = 0;

	pacr_config_store pacr_config_store_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .pixel_enable_bits(pixel_enable_bits), .col_sel(col_sel),
		.col_shunt(col_shunt));
	pacr_nvm_model pacr_nvm_model_i (.nvm_addr(nvm_addr), .nvm_data(nvm_data));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========================================
	// Tasks
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Each task starts and ends just after a rising edge.
	task wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask

	task rd(input logic [15:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b0;
		chk({7'h00, reg_rvalid}, 8'h01);
		chk(reg_rdata, exp);
		@(posedge sys_clk);
		#1;
		chk({7'h00, reg_rvalid}, 8'h00);
	endtask

	// Writes a byte and reads it back at the very next edge.
	task wr_rd(input logic [15:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b0;
		chk({7'h00, reg_rvalid}, 8'h01);
		chk(reg_rdata, d);
		@(posedge sys_clk);
		#1;
	endtask

	task summarize;
		$display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		#50000;
		fail_count++;
		summarize;
	end

	// ==========================================
	// Tests
	initial
	begin
		int r;
		int p;
		logic [3:0] n;
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		nvm_addr = 10'h000;
		repeat (6) @(posedge sys_clk);
		#1;
		chk({7'h00, &col_shunt}, 8'h01);
		chk({7'h00, reg_rvalid}, 8'h00);
		chk(reg_rdata, 8'h00);
		sys_rst = 1'b0;
		for (int i = 0; i < 544; i++)
		begin
			nvm_addr = 10'(i);
			#0;
			if (i < 512)
				wr({7'h00, 6'(i >> 3), 1'(i), 2'(i >> 1)}, nvm_data);
			else
				wr(16'(i + 512), nvm_data);
		end
		for (int i = 0; i < 512; i++)
		begin
			r = i >> 3;
			p = i & 7;
			chk(pixel_enable_bits[r * 64 + p * 8 +: 8], 8'(i) ^ 8'h5a);
		end
		for (int c = 0; c < 64; c++)
		begin
			n = c[0] ? 4'(c / 2 + 3) : 4'(c / 2);
			chk({2'b00, col_sel[c * 6 +: 6]}, (n < 6) ? (8'h01 << n) : 8'h00);
			chk({7'h00, col_shunt[c]}, {7'h00, n > 5});
		end
		$display("Test load done");
		rd(16'h01ff, 8'ha5);
		rd(16'h0004, 8'h5b);
		rd(16'h041f, 8'h2f);
		$display("Test readback done");
		wr(16'h0200, 8'hff);
		rd(16'h0200, 8'h00);
		rd(16'h0420, 8'h00);
		rd(16'h0000, 8'h5a);
		$display("Test unmapped done");
		wr(16'h0400, 8'h52);
		chk({2'b00, col_sel[5:0]}, 8'h04);
		chk({2'b00, col_sel[11:6]}, 8'h20);
		wr(16'h0008, 8'h81);
		chk(pixel_enable_bits[71:64], 8'h81);
		$display("Test rewrite done");
		wr_rd(16'h0123, 8'h3c);
		wr_rd(16'h0410, 8'hc6);
		reg_addr = 16'h0008;
		reg_wdata = 8'h18;
		reg_wr = 1'b1;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chk({7'h00, reg_rvalid}, 8'h01);
		chk(reg_rdata, 8'h81);
		@(posedge sys_clk);
		#1;
		rd(16'h0008, 8'h18);
		chk(pixel_enable_bits[71:64], 8'h18);
		$display("Test order done");
		sys_rst = 1'b1;
		@(posedge sys_clk);
		#1;
		chk(reg_rdata, 8'h00);
		chk({7'h00, reg_rvalid}, 8'h00);
		chk({7'h00, &col_shunt}, 8'h01);
		chk(col_sel[7:0], 8'h00);
		sys_rst = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk({2'b00, col_sel[5:0]}, 8'h04);
		chk(pixel_enable_bits[71:64], 8'h18);
		rd(16'h0123, 8'h3c);
		$display("Test reset done");
		summarize;
	end
endmodule
